// file: bench/iplc_core_model.sv
// Core and peripheral modules: hold request flags, clear them in handlers, return.
`timescale 1ns/1ps
`default_nettype none
module iplc_core_model (
    // Clock and reset.
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Accept from the block.
    input  wire logic        i_irq_take,
    input  wire logic [15:0] i_vector,
    // Requests and return.
    output logic      [27:0] o_flags = 28'h0000000,
    output logic             o_ret = 1'b0
);
    int ret_wait = 0;
    int cnt = -1;
    // A flag stays in its module until its handler clears it.
    task automatic post(input logic [27:0] b);
        o_flags <= o_flags | b;
    endtask
    // Each shared handler clears every flag of its group: three for fffc and fff0, eight for each port.
    function automatic logic [27:0] served(input logic [15:0] v);
        case (v)
            16'hfffe: served = 28'h0000001;
            16'hfffc: served = 28'h000000e;
            16'hfff4: served = 28'h0000010;
            16'hfff2: served = 28'h0000020;
            16'hfff0: served = 28'h00001c0;
            16'hffee: served = 28'h0000200;
            16'hffec: served = 28'h0000400;
            16'hffea: served = 28'h0000800;
            16'hffe6: served = 28'h00ff000;
            16'hffe4: served = 28'hff00000;
            default:  served = 28'h0000000;
        endcase
    endfunction
    // A reset fetch never returns; other handlers return ret_wait+1 cycles after the accept.
    always @(posedge i_mclk) begin
        o_ret <= 1'b0;
        if (i_rst) begin
            cnt <= -1;
        end else if (i_irq_take) begin
            o_flags <= o_flags & ~served(i_vector);
            cnt <= (i_vector == 16'hfffe) ? -1 : ret_wait;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            o_ret <= 1'b1;
            cnt <= -1;
        end
    end
endmodule
`default_nettype wire

// file: bench/iplc_ctrl_chk.sv
// Port assertions for the interrupt priority and low-power block.
`timescale 1ns/1ps
`default_nettype none
module iplc_ctrl_chk (
    // Clock, reset and bus.
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        o_pready,
    // Requests.
    input wire logic        i_reset_src,
    input wire logic        i_ext_nmi_flag,
    input wire logic        i_osc_fault_flag,
    input wire logic        i_flash_access_violation_flag,
    input wire logic        i_watchdog_flag,
    input wire logic        i_timer_ch0_flag,
    input wire logic [7:0]  i_port1_pin_flags,
    // Accept and run outputs.
    input wire logic        o_irq_take,
    input wire logic [15:0] o_vector,
    input wire logic        o_mclk_run,
    input wire logic        o_periph_sub_clock_run,
    input wire logic        o_dc_gen_run,
    input wire logic        o_low_freq_crystal_osc_run
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Short names keep each property on one line.
    wire       tk  = o_irq_take;
    wire [3:0] rn  = {o_mclk_run, o_periph_sub_clock_run, o_dc_gen_run, o_low_freq_crystal_osc_run};
    wire       nmi = i_ext_nmi_flag | i_osc_fault_flag | i_flash_access_violation_flag;
    apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("setup got no answer");
    wake_all_a: assert property (tk |-> rn == 4'hf)
        else $error("accept left a clock stopped");
    take_single_a: assert property (tk |=> !tk [*2])
        else $error("second accept before return");
    vec_range_a: assert property (tk |-> o_vector >= 16'hffe0 && !o_vector[0])
        else $error("vector outside table");
    reset_first_a: assert property (tk && $past(i_reset_src) |-> o_vector == 16'hfffe)
        else $error("reset request lost priority");
    nmi_source_a: assert property (tk && o_vector == 16'hfffc |-> $past(nmi))
        else $error("shared vector without source");
    wdt_first_a: assert property (tk && o_vector == 16'hfff2 |-> !$past(i_watchdog_flag))
        else $error("timer beat watchdog");
    port1_src_a: assert property (tk && o_vector == 16'hffe4 |-> |$past(i_port1_pin_flags))
        else $error("port vector without flag");
    take_pending_a: assert property (tk |-> o_vector != 16'hffe0)
        else $error("accept without a pending request");
    cover property (tk && o_vector == 16'hfffe);
    cover property (tk && o_vector == 16'hfffc);
    cover property (tk && o_vector == 16'hffe4);
endmodule
bind iplc_ctrl iplc_ctrl_chk iplc_ctrl_chk_inst (.*);
`default_nettype wire

// file: bench/tb_iplc_ctrl.sv
// Self-checking bench for the interrupt priority and low-power block.
`timescale 1ns/1ps
`default_nettype none
module tb_iplc_ctrl;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h00000000;
    logic [31:0] prd;
    logic [31:0] rd;
    logic        rdy;
    logic        err;
    logic        tk;
    logic        irq;
    logic        ret;
    logic        irq_a;
    logic [15:0] vec;
    logic [4:0]  run;
    logic [27:0] fl;
    bit          seen;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;
    // Gating cases: status word and expected {main, sub, dc gen, crystal}.
    logic [15:0] gsw [6] = '{16'h0010, 16'h00c0, 16'h00d0, 16'h0050, 16'h0020, 16'h0060};
    logic [3:0]  gex [6] = '{4'h7, 4'hb, 4'h1, 4'h7, 4'he, 4'hd};
    logic [15:0] vecs [8] = '{16'hfff4, 16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea,
                              16'hffe6, 16'hffe4};
    always #10 i_mclk = ~i_mclk;
    iplc_ctrl iplc_ctrl_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
        .i_reset_src(fl[0]), .i_ext_nmi_flag(fl[1]), .i_osc_fault_flag(fl[2]),
        .i_flash_access_violation_flag(fl[3]), .i_watchdog_flag(fl[4]),
        .i_timer_ch0_flag(fl[5]), .i_timer_ch1_flag(fl[6]), .i_timer_ch2_flag(fl[7]),
        .i_timer_overflow_flag(fl[8]), .i_serial_rx_flag(fl[9]), .i_serial_tx_flag(fl[10]),
        .i_converter_done_flag(fl[11]), .i_port2_pin_flags(fl[19:12]),
        .i_port1_pin_flags(fl[27:20]), .i_return_from_interrupt(ret), .o_irq_take(tk),
        .o_vector(vec), .o_mclk_run(run[4]), .o_periph_sub_clock_run(run[3]),
        .o_dc_gen_run(run[2]), .o_low_freq_crystal_osc_run(run[1]),
        .o_digital_osc_clock_run(run[0]), .o_irq(irq));
    iplc_core_model iplc_core_model_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_irq_take(tk), .i_vector(vec), .o_flags(fl),
        .o_ret(ret));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge i_mclk);
        pen <= 1'b1;
        do begin
            @(posedge i_mclk);
        end while (rdy !== 1'b1);
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic wt(input int lim, input bit e);
        seen = 0;
        for (int k = 0; k < lim && !seen; k++) begin
            @(posedge i_mclk);
            seen = (tk === 1'b1);
        end
        chk("take", {31'h0, e}, {31'h0, seen});
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // A hang counts as a mismatch; the whole run needs under two thousand cycles.
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        chk("run", 32'h1f, run);
        rchk("status", 12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'hffffffff);
        rchk("status bits", 12'h000, 32'h1ff);
        rchk("unmapped", 12'h020, 32'h0);
        chk("slverr", 32'h0, err);
        chk("halted", 32'h0, run[4:3]);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h008, (i == 5) ? 32'h3 : 32'h0);
            apb(1'b1, 12'h000, {16'h0, gsw[i]});
            @(posedge i_mclk);
            chk("gating", gex[i], run[4:1]);
        end
        chk("dco", 32'h0, run[0]);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h004, 32'h1f);
        apb(1'b1, 12'h000, 32'h0);
        iplc_core_model_inst.ret_wait = 40;
        iplc_core_model_inst.post(28'h0301ff0);
        apb(1'b1, 12'h000, 32'hf8);
        wt(20, 1'b1);
        chk("vector", vecs[0], vec);
        chk("woken", 32'hf, run[4:1]);
        rchk("handler status", 12'h000, 32'h0);
        rchk("stacked", 12'h018, 32'hf8);
        apb(1'b1, 12'h018, 32'h80);
        for (int k = 0; k < 60 && run[3] !== 1'b0; k++) @(posedge i_mclk);
        rchk("resumed", 12'h000, 32'h80);
        chk("resumed clocks", 32'h2, run[4:3]);
        iplc_core_model_inst.ret_wait = 1;
        apb(1'b1, 12'h000, 32'h8);
        for (int i = 1; i < 8; i++) begin
            wt(20, 1'b1);
            chk("order", vecs[i], vec);
        end
        wt(8, 1'b0);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        iplc_core_model_inst.post(28'h0000012);
        wt(12, 1'b0);
        apb(1'b1, 12'h004, 32'h1);
        wt(12, 1'b1);
        chk("nmi vector", 32'hfffc, vec);
        // Let the handler's own flag clear land before posting a new flag.
        @(posedge i_mclk);
        iplc_core_model_inst.post(28'h0000001);
        wt(12, 1'b1);
        chk("reset vector", 32'hfffe, vec);
        rchk("reset status", 12'h000, 32'h0);
        rchk("vector reg", 12'h00c, 32'h1fffe);
        apb(1'b1, 12'h000, 32'h8);
        wt(12, 1'b1);
        chk("watchdog", 32'hfff4, vec);
        rchk("events", 12'h010, 32'h3);
        apb(1'b1, 12'h014, 32'h0);
        irq_a = irq;
        apb(1'b1, 12'h014, 32'h3);
        chk("irq mask", 32'h1, irq_a ^ irq);
        apb(1'b1, 12'h010, 32'h3);
        rchk("events clear", 12'h010, 32'h0);
        chk("irq low", 32'h0, irq);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: design/iplc_ctrl.sv
// Fixed-priority interrupt vectoring with low-power clock gating controls.
`include "iplc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module iplc_ctrl (
    // Clock and reset.
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Request inputs from modules, same clock.
    input  wire logic        i_reset_src,
    input  wire logic        i_ext_nmi_flag,
    input  wire logic        i_osc_fault_flag,
    input  wire logic        i_flash_access_violation_flag,
    input  wire logic        i_watchdog_flag,
    input  wire logic        i_timer_ch0_flag,
    input  wire logic        i_timer_ch1_flag,
    input  wire logic        i_timer_ch2_flag,
    input  wire logic        i_timer_overflow_flag,
    input  wire logic        i_serial_rx_flag,
    input  wire logic        i_serial_tx_flag,
    input  wire logic        i_converter_done_flag,
    input  wire logic [7:0]  i_port2_pin_flags,
    input  wire logic [7:0]  i_port1_pin_flags,
    // Processor core handshake.
    input  wire logic        i_return_from_interrupt,
    // Vector and clock gating outputs.
    output logic             o_irq_take,
    output logic      [15:0] o_vector,
    output logic             o_mclk_run,
    output logic             o_periph_sub_clock_run,
    output logic             o_dc_gen_run,
    output logic             o_digital_osc_clock_run,
    output logic             o_low_freq_crystal_osc_run,
    // Interrupt to the system.
    output logic             o_irq
);

    iplc_pkg::iplc_regs_t r_reg;
    iplc_pkg::iplc_regs_t r_next;

    logic        wr;
    logic        rd;
    logic        nmi_req;
    logic        maskable_ok;
    logic        pend;
    logic [15:0] vec;
    logic        is_reset;
    logic [15:0] sw_eff;
    logic        sel_main_dco;
    logic        sel_main_xtal;
    logic        sel_sub_dco;

    // Bus decode: access phase completes at once, so the slave answers in the
    // same cycle penable rises.
    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && !i_penable && !i_pwrite;

    // Non-maskable group gated only by its own enables, never by GLOBAL_IRQ_ENABLE.
    assign nmi_req = (i_ext_nmi_flag && r_reg.irq_en[0]) ||
                     (i_osc_fault_flag && r_reg.irq_en[1]) ||
                     (i_flash_access_violation_flag && r_reg.irq_en[2]);
    assign maskable_ok = r_reg.sw[`IPLC_SW_GIE];

    // Fixed priority encoder, highest number first.
    always_comb begin
        pend     = 1'b1;
        is_reset = 1'b0;
        if (i_reset_src) begin
            vec      = `IPLC_VEC_RESET;
            is_reset = 1'b1;
        end else if (nmi_req) begin
            vec = `IPLC_VEC_NMI;
        end else if (maskable_ok && i_watchdog_flag) begin
            vec = `IPLC_VEC_WDT;
        end else if (maskable_ok && i_timer_ch0_flag) begin
            vec = `IPLC_VEC_TMR0;
        end else if (maskable_ok && (i_timer_ch1_flag || i_timer_ch2_flag ||
                                     i_timer_overflow_flag)) begin
            vec = `IPLC_VEC_TMRX;
        end else if (maskable_ok && i_serial_rx_flag && r_reg.irq_en[3]) begin
            vec = `IPLC_VEC_RX;
        end else if (maskable_ok && i_serial_tx_flag && r_reg.irq_en[4]) begin
            vec = `IPLC_VEC_TX;
        end else if (maskable_ok && i_converter_done_flag) begin
            vec = `IPLC_VEC_ADC;
        end else if (maskable_ok && (|i_port2_pin_flags)) begin
            vec = `IPLC_VEC_P2;
        end else if (maskable_ok && (|i_port1_pin_flags)) begin
            vec = `IPLC_VEC_P1;
        end else begin
            vec  = `IPLC_VEC_LOW;
            pend = 1'b0;
        end
    end

    // Clock gating from the status word, with source selection overriding
    // the off requests for oscillators still in use.
    always_comb begin
        sw_eff        = r_next.sw;
        sel_main_dco  = !r_reg.clksel[1];
        sel_main_xtal = r_reg.clksel[1];
        sel_sub_dco   = !r_reg.clksel[0];
    end

    // Next-state logic for the whole block.
    always_comb begin
        r_next        = r_reg;
        r_next.take   = 1'b0;
        r_next.pready = 1'b0;
        r_next.prdata = 32'h0000_0000;

        // Register writes; unassigned bits are never stored.
        if (wr) begin
            unique case (i_paddr)
                `IPLC_OFS_STATUS:   r_next.sw = i_pwdata[15:0] & `IPLC_SW_USED;
                `IPLC_OFS_IRQ_EN:   r_next.irq_en = i_pwdata[4:0] & `IPLC_EN_USED;
                `IPLC_OFS_CLKSEL:   r_next.clksel = i_pwdata[1:0];
                `IPLC_OFS_EVT_MASK: r_next.evt_mask = i_pwdata[1:0];
                `IPLC_OFS_STACKED:  r_next.stacked = i_pwdata[15:0] & `IPLC_SW_USED;
                default: ;
            endcase
        end

        // Sticky event clear by writing ones.
        if (wr && i_paddr == `IPLC_OFS_EVT) begin
            r_next.evt = r_reg.evt & ~i_pwdata[1:0];
        end

        // Service sequencing.
        unique case (r_reg.state)
            iplc_pkg::IPLC_IDLE: begin
                if (pend) begin
                    r_next.state = iplc_pkg::IPLC_ACCEPT;
                end
            end
            iplc_pkg::IPLC_ACCEPT: begin
                if (!pend) begin
                    // The request vanished, for example a reset source cleared by
                    // its handler; taking now would hand out an empty vector.
                    r_next.state = iplc_pkg::IPLC_IDLE;
                end else begin
                    // Save the status word, then run the handler at full clock.
                    r_next.stacked = r_reg.sw;
                    r_next.sw      = r_reg.sw & `IPLC_SW_LPCLR;
                    r_next.sw[`IPLC_SW_GIE] = 1'b0;
                    r_next.vector  = vec;
                    r_next.reset_req = is_reset;
                    r_next.take    = 1'b1;
                    r_next.state   = iplc_pkg::IPLC_SERVE;
                    if (is_reset) begin
                        r_next.sw    = `IPLC_SW_RESET;
                        r_next.state = iplc_pkg::IPLC_IDLE;
                    end
                end
            end
            iplc_pkg::IPLC_SERVE: begin
                if (i_return_from_interrupt) begin
                    r_next.sw    = r_reg.stacked;
                    r_next.state = iplc_pkg::IPLC_IDLE;
                end
            end
            default: r_next.state = iplc_pkg::IPLC_IDLE;
        endcase

        // Events set wins over a same-cycle clear.
        if (r_next.take) begin
            r_next.evt[0] = 1'b1;
        end
        if (r_reg.state == iplc_pkg::IPLC_SERVE && i_return_from_interrupt) begin
            r_next.evt[1] = 1'b1;
        end
        r_next.irq = |(r_next.evt & r_next.evt_mask);

        // Clock gating from the upcoming status word.
        r_next.mclk_run  = !sw_eff[`IPLC_SW_HALT];
        r_next.periph_sub_clock_run = !sw_eff[`IPLC_SW_SCDIS];
        r_next.dco_run   = sel_main_dco;
        r_next.dcgen_run = !sw_eff[`IPLC_SW_DCOFF] ||
                           (!sw_eff[`IPLC_SW_HALT] && sel_main_dco) ||
                           (!sw_eff[`IPLC_SW_SCDIS] && sel_sub_dco);
        r_next.xtal_run  = !sw_eff[`IPLC_SW_XOFF] ||
                           (!sw_eff[`IPLC_SW_HALT] && sel_main_xtal) ||
                           (!sw_eff[`IPLC_SW_SCDIS] && !sel_sub_dco);

        // Read data prepared in setup, presented with pready in access.
        if (rd) begin
            r_next.pready = 1'b1;
            unique case (i_paddr)
                `IPLC_OFS_STATUS:   r_next.prdata = {16'h0000, r_reg.sw};
                `IPLC_OFS_IRQ_EN:   r_next.prdata = {27'h0000000, r_reg.irq_en};
                `IPLC_OFS_CLKSEL:   r_next.prdata = {30'h00000000, r_reg.clksel};
                `IPLC_OFS_VECTOR:   r_next.prdata = {15'h0000, r_reg.reset_req, r_reg.vector};
                `IPLC_OFS_EVT:      r_next.prdata = {30'h00000000, r_reg.evt};
                `IPLC_OFS_EVT_MASK: r_next.prdata = {30'h00000000, r_reg.evt_mask};
                `IPLC_OFS_STACKED:  r_next.prdata = {16'h0000, r_reg.stacked};
                default:            r_next.prdata = 32'h0000_0000;
            endcase
        end else if (i_psel && !i_penable) begin
            r_next.pready = 1'b1;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_reg           <= '0;
            r_reg.state     <= iplc_pkg::IPLC_IDLE;
            r_reg.sw        <= `IPLC_SW_RESET;
            r_reg.irq_en    <= `IPLC_EN_RESET;
            r_reg.vector    <= `IPLC_VEC_RESET;
            r_reg.mclk_run  <= 1'b1;
            r_reg.periph_sub_clock_run <= 1'b1;
            r_reg.dcgen_run <= 1'b1;
            r_reg.dco_run   <= 1'b1;
            r_reg.xtal_run  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flip-flops, except o_pslverr, which is tied low.
    assign o_prdata                   = r_reg.prdata;
    assign o_pready                   = r_reg.pready;
    assign o_pslverr                  = 1'b0;
    assign o_irq_take                 = r_reg.take;
    assign o_vector                   = r_reg.vector;
    assign o_mclk_run                 = r_reg.mclk_run;
    assign o_periph_sub_clock_run     = r_reg.periph_sub_clock_run;
    assign o_dc_gen_run               = r_reg.dcgen_run;
    assign o_digital_osc_clock_run    = r_reg.dco_run;
    assign o_low_freq_crystal_osc_run = r_reg.xtal_run;
    assign o_irq                      = r_reg.irq;

endmodule

`default_nettype wire

// file: design/iplc_map.svh
// Register offsets, field positions, reset values and vector addresses of the interrupt block.
`ifndef IPLC_MAP_SVH
`define IPLC_MAP_SVH

// APB register byte offsets.
`define IPLC_OFS_STATUS   12'h000
`define IPLC_OFS_IRQ_EN   12'h004
`define IPLC_OFS_CLKSEL   12'h008
`define IPLC_OFS_VECTOR   12'h00c
`define IPLC_OFS_EVT      12'h010
`define IPLC_OFS_EVT_MASK 12'h014
`define IPLC_OFS_STACKED  12'h018

// Status word field positions.
`define IPLC_SW_C     0
`define IPLC_SW_Z     1
`define IPLC_SW_N     2
`define IPLC_SW_GIE   3
`define IPLC_SW_HALT  4
`define IPLC_SW_XOFF  5
`define IPLC_SW_DCOFF 6
`define IPLC_SW_SCDIS 7
`define IPLC_SW_V     8
`define IPLC_SW_USED  16'h01ff
`define IPLC_SW_RESET 16'h0000
`define IPLC_SW_LPCLR 16'hff07

// Enable register layout: 0 nmi, 1 osc fault, 2 access violation, 3 serial rx, 4 serial tx.
`define IPLC_EN_USED  5'h1f
`define IPLC_EN_RESET 5'h00

// Vector word addresses.
`define IPLC_VEC_RESET  16'hfffe
`define IPLC_VEC_NMI    16'hfffc
`define IPLC_VEC_WDT    16'hfff4
`define IPLC_VEC_TMR0   16'hfff2
`define IPLC_VEC_TMRX   16'hfff0
`define IPLC_VEC_RX     16'hffee
`define IPLC_VEC_TX     16'hffec
`define IPLC_VEC_ADC    16'hffea
`define IPLC_VEC_P2     16'hffe6
`define IPLC_VEC_P1     16'hffe4
`define IPLC_VEC_LOW    16'hffe0

`endif

// file: design/iplc_pkg.sv
// Types shared by the interrupt priority and low-power block.
package iplc_pkg;

    // Request service state, Gray coded along idle, accept, wait return.
    typedef enum logic [1:0] {
        IPLC_IDLE   = 2'b00,
        IPLC_ACCEPT = 2'b01,
        IPLC_SERVE  = 2'b11
    } iplc_state_t;

    // Whole block state.
    typedef struct packed {
        iplc_state_t state;
        logic [15:0] sw;
        logic [15:0] stacked;
        logic [4:0]  irq_en;
        logic [1:0]  clksel;
        logic [15:0] vector;
        logic        reset_req;
        logic [1:0]  evt;
        logic [1:0]  evt_mask;
        logic [31:0] prdata;
        logic        pready;
        logic        irq;
        logic        take;
        logic        mclk_run;
        logic        periph_sub_clock_run;
        logic        dcgen_run;
        logic        dco_run;
        logic        xtal_run;
    } iplc_regs_t;

endpackage
